// File: tci2c_target.sv
// I2C target access logic: address match, register writes, pointer reads and FIFO readback.
// Behaviour
// - Answer address 10010 plus strapped pins.
// - Write each address-data pair in turn.
// - Reads return pointer register, then following ones.
// - Pointer advances each byte, ack or not.
// - Result reads saturate at last result register.
// - FIFO port pointer never advances.
// - FIFO block consumed once first byte starts.
// - Shortened read resumes from stored pointer.
// - Streamlined readback can be switched off.
// - Shortened reads stay on FIFO port.
// - Accepted XY command points at X high.
// - Only accepted XY command overwrites pointer.
// - Write leaves pointer at last written register.
// - Conversion command must stand alone.
// - Busy-time conversion commands discarded, pointer kept.
// - Config 00h-0Bh, FIFO port at 50h.
// - Results at 52h-58h, direct mode only.
// - Setup 6Ah-6Fh, measurement 70h-7Fh.
// - Each unit is eight bits plus acknowledge.
// - Command MSB ignored on writes.
// - FIFO oldest first, end marker when empty.
// - Pending result read is tagged invalid.
`timescale 1ns/1ns
module tci2c_target (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output tci2c_pkg::tci2c_sda_drv_s sda_drv_out,
   input wire logic [1:0] addr_sel_in,
   input wire logic stream_en_in,
   input wire logic auto_mode_in,
   input wire logic conv_busy_in,
   output tci2c_pkg::tci2c_reg_wr_s reg_wr_out,
   output tci2c_pkg::tci2c_cmd_s cmd_out,
   output logic [6:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   input wire logic rd_pending_in,
   input wire logic fifo_empty_in,
   input wire logic [7:0] fifo_data_in,
   output logic fifo_pop_out,
   output logic fifo_byte_adv_out,
   output logic [6:0] ptr_out
);
   import tci2c_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_WBYTE = 6'b000100,
      ST_WACK = 6'b001000,
      ST_RBYTE = 6'b010000,
      ST_RACK = 6'b100000
   } tci2c_state_e;

   tci2c_state_e state_ff;
   logic scl_s;
   logic sda_s;
   logic scl_d_ff;
   logic sda_d_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [6:0] ptr_ff;
   logic [6:0] ptr_inc;
   logic [6:0] wr_addr_ff;
   logic have_addr_ff;
   logic addr_phase_ff;
   logic bytes_ff;
   logic is_cmd_ff;
   logic [6:0] cmd_code_ff;
   logic streamed_ff;
   logic fifo_armed_ff;
   logic [1:0] fifo_idx_ff;
   logic ack_drive_ff;
   logic sda_o_ff;
   logic sda_oe_ff;
   tci2c_reg_wr_s reg_wr_ff;
   tci2c_cmd_s cmd_ff;
   logic pop_ff;
   logic adv_ff;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] rx_byte;
   logic [7:0] rd_byte;

   function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo,
                                     input logic [6:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic is_conv(input logic [6:0] a);
      is_conv = in_range(a, TCI2C_SETUP_FIRST, TCI2C_SETUP_LAST) ||
                in_range(a, TCI2C_MEAS_FIRST, TCI2C_MEAS_LAST);
   endfunction : is_conv

   tci2c_sync u_scl_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in(scl_in),
      .sync_out(scl_s)
   );

   tci2c_sync u_sda_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   tci2c_ptr u_ptr (
      .ptr_in(ptr_ff),
      .nxt_ptr_out(ptr_inc)
   );

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
   assign stop_cond = scl_s && scl_d_ff && !sda_d_ff && sda_s;
   assign rx_byte = {shift_ff[6:0], sda_s};

   // Byte served for the current pointer; unmapped and wrong-mode places read zero.
   always_comb begin
      if (ptr_ff == TCI2C_FIFO_PORT) begin
         if (!auto_mode_in) begin
            rd_byte = TCI2C_UNMAPPED_BYTE;
         end else if (fifo_empty_in && fifo_idx_ff == 2'h0) begin
            rd_byte = TCI2C_EOF_BYTE;
         end else begin
            rd_byte = fifo_data_in;
         end
      end else if (in_range(ptr_ff, TCI2C_RES_FIRST, TCI2C_RES_LAST)) begin
         if (auto_mode_in) begin
            rd_byte = TCI2C_UNMAPPED_BYTE;
         end else if (rd_pending_in) begin
            rd_byte = {rd_data_in[7:1], 1'b1};
         end else begin
            rd_byte = rd_data_in;
         end
      end else if (in_range(ptr_ff, TCI2C_CFG_FIRST, TCI2C_CFG_LAST)) begin
         rd_byte = rd_data_in;
      end else begin
         rd_byte = TCI2C_UNMAPPED_BYTE;
      end
   end

   // Bit and byte framing: eight data bits then one acknowledge slot.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= TCI2C_BIT_RESET;
         shift_ff <= 8'h00;
      end else if (start_cond) begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= TCI2C_BIT_RESET;
      end else if (stop_cond) begin
         state_ff <= ST_IDLE;
      end else if (scl_rise) begin
         case (state_ff)
            ST_ADDR, ST_WBYTE: begin
               shift_ff <= rx_byte;
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            ST_RBYTE: begin
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            ST_RACK: begin
               // Only a NACK in the master's slot ends the read; the pointer moves anyway.
               state_ff <= (!ack_drive_ff && sda_s) ? ST_IDLE : ST_RACK;
               bit_cnt_ff <= TCI2C_BIT_RESET;
            end
            default: begin
            end
         endcase
      end else if (scl_fall && bit_cnt_ff == 4'h8) begin
         bit_cnt_ff <= TCI2C_BIT_RESET;
         case (state_ff)
            ST_ADDR: begin
               if (shift_ff[7:1] == {TCI2C_ADDR_HI, addr_sel_in}) begin
                  state_ff <= shift_ff[0] ? ST_RACK : ST_WACK;
               end else begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_WBYTE: state_ff <= ST_WACK;
            ST_RBYTE: state_ff <= ST_RACK;
            default: begin
            end
         endcase
      end else if (scl_fall && state_ff == ST_WACK) begin
         state_ff <= ST_WBYTE;
      end else if (scl_fall && state_ff == ST_RACK) begin
         state_ff <= ST_RBYTE;
      end
   end

   // The address acknowledge of a read enters the acknowledge slot, so the first
   // data byte is loaded on the falling edge that ends it.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ack_drive_ff <= 1'b0;
      end else if (start_cond || stop_cond) begin
         ack_drive_ff <= 1'b0;
      end else if (scl_fall && bit_cnt_ff == 4'h8) begin
         ack_drive_ff <= (state_ff == ST_WBYTE) ||
                         (state_ff == ST_ADDR && shift_ff[7:1] == {TCI2C_ADDR_HI, addr_sel_in});
      end else if (scl_fall) begin
         ack_drive_ff <= 1'b0;
      end
   end

   // Write phase: register address, then data, alternating.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         addr_phase_ff <= 1'b1;
         have_addr_ff <= 1'b0;
         bytes_ff <= 1'b0;
         is_cmd_ff <= 1'b0;
         cmd_code_ff <= 7'h00;
         wr_addr_ff <= 7'h00;
         reg_wr_ff <= '0;
      end else begin
         reg_wr_ff.valid <= 1'b0;
         if (start_cond) begin
            addr_phase_ff <= 1'b1;
            bytes_ff <= 1'b0;
            is_cmd_ff <= 1'b0;
         end else if (stop_cond) begin
            have_addr_ff <= 1'b0;
         end else if (scl_fall && bit_cnt_ff == 4'h8 && state_ff == ST_WBYTE) begin
            if (addr_phase_ff) begin
               wr_addr_ff <= shift_ff[6:0];
               have_addr_ff <= 1'b1;
               is_cmd_ff <= is_conv(shift_ff[6:0]) && !bytes_ff;
               cmd_code_ff <= shift_ff[6:0];
               addr_phase_ff <= is_conv(shift_ff[6:0]);
            end else begin
               reg_wr_ff.valid <= 1'b1;
               reg_wr_ff.addr <= wr_addr_ff;
               reg_wr_ff.data <= shift_ff;
               addr_phase_ff <= 1'b1;
            end
            bytes_ff <= 1'b1;
         end
      end
   end

   // A conversion code is issued at stop, only if it stood alone.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cmd_ff <= '0;
      end else begin
         cmd_ff.valid <= stop_cond && is_cmd_ff && !conv_busy_in;
         cmd_ff.code <= cmd_code_ff;
      end
   end

   // Pointer: set by writes, the XY command and full reads; advanced per read byte.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ptr_ff <= TCI2C_PTR_RESET;
         streamed_ff <= 1'b0;
      end else begin
         if (reg_wr_ff.valid) begin
            ptr_ff <= reg_wr_ff.addr;
         end else if (stop_cond && is_cmd_ff) begin
            if (!conv_busy_in && cmd_code_ff == TCI2C_XY_CMD) begin
               ptr_ff <= TCI2C_RES_FIRST;
            end
         end else if (scl_fall && bit_cnt_ff == 4'h8 && state_ff == ST_WBYTE && addr_phase_ff
                      && !is_conv(shift_ff[6:0])) begin
            ptr_ff <= shift_ff[6:0];
         end else if (scl_rise && state_ff == ST_RACK && !ack_drive_ff) begin
            ptr_ff <= ptr_inc;
         end
         if (start_cond) begin
            streamed_ff <= 1'b0;
         end else if (scl_fall && bit_cnt_ff == 4'h8 && state_ff == ST_ADDR && shift_ff[0]) begin
            streamed_ff <= !have_addr_ff;
         end
      end
   end

   // Transmit shifter; a disabled streamlined read returns unmapped data.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tx_ff <= 8'h00;
         sda_o_ff <= 1'b1;
         sda_oe_ff <= 1'b0;
      end else if (start_cond || stop_cond) begin
         sda_oe_ff <= 1'b0;
      end else if (scl_fall) begin
         if ((state_ff == ST_ADDR || state_ff == ST_WBYTE) && bit_cnt_ff == 4'h8) begin
            sda_o_ff <= 1'b0;
            sda_oe_ff <= ack_drive_next();
         end else if (state_ff == ST_RACK) begin
            if (streamed_ff && !stream_en_in) begin
               tx_ff <= {TCI2C_UNMAPPED_BYTE[6:0], 1'b0};
               sda_o_ff <= 1'b0;
            end else begin
               tx_ff <= {rd_byte[6:0], 1'b0};
               sda_o_ff <= rd_byte[7];
            end
            sda_oe_ff <= 1'b1;
         end else if (state_ff == ST_RBYTE && bit_cnt_ff < 4'h8) begin
            sda_o_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
            sda_oe_ff <= 1'b1;
         end else begin
            sda_oe_ff <= 1'b0;
         end
      end
   end

   function automatic logic ack_drive_next();
      ack_drive_next = (state_ff == ST_WBYTE) ||
                       (shift_ff[7:1] == {TCI2C_ADDR_HI, addr_sel_in});
   endfunction : ack_drive_next

   // FIFO block bookkeeping: the block is popped on the first bit of its first byte.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         fifo_idx_ff <= 2'h0;
         fifo_armed_ff <= 1'b0;
         pop_ff <= 1'b0;
         adv_ff <= 1'b0;
      end else begin
         pop_ff <= 1'b0;
         adv_ff <= 1'b0;
         if (state_ff == ST_RACK && scl_fall) begin
            fifo_armed_ff <= ptr_ff == TCI2C_FIFO_PORT && auto_mode_in && !fifo_empty_in;
         end
         if (fifo_armed_ff && state_ff == ST_RBYTE && scl_rise && bit_cnt_ff == 4'h0) begin
            fifo_armed_ff <= 1'b0;
            if (fifo_idx_ff == 2'h0) begin
               pop_ff <= 1'b1;
            end
         end
         if (state_ff == ST_RBYTE && scl_fall && bit_cnt_ff == 4'h8
             && ptr_ff == TCI2C_FIFO_PORT && auto_mode_in) begin
            adv_ff <= 1'b1;
            fifo_idx_ff <= (fifo_idx_ff == TCI2C_FIFO_BYTE_LAST) ? 2'h0 : fifo_idx_ff + 2'h1;
         end
         if (start_cond && fifo_idx_ff != 2'h0) begin
            fifo_idx_ff <= 2'h0;
         end
      end
   end

   assign sda_drv_out.sda_out = sda_o_ff;
   assign sda_drv_out.sda_oe = sda_oe_ff;
   assign reg_wr_out = reg_wr_ff;
   assign cmd_out = cmd_ff;
   assign rd_addr_out = ptr_ff;
   assign fifo_pop_out = pop_ff;
   assign fifo_byte_adv_out = adv_ff;
   assign ptr_out = ptr_ff;
endmodule : tci2c_target

// File: tci2c_pkg.sv
// Shared constants and carrier types for the touch controller I2C target logic.
package tci2c_pkg;
   localparam logic [4:0] TCI2C_ADDR_HI = 5'h12;
   localparam int TCI2C_SYNC_STAGES = 3;
   localparam int TCI2C_BITS_PER_UNIT = 9;
   localparam logic [6:0] TCI2C_CFG_FIRST = 7'h00;
   localparam logic [6:0] TCI2C_CFG_LAST = 7'h0b;
   localparam logic [6:0] TCI2C_OPMODE_REG = 7'h0b;
   localparam logic [6:0] TCI2C_FIFO_PORT = 7'h50;
   localparam logic [6:0] TCI2C_RES_FIRST = 7'h52;
   localparam logic [6:0] TCI2C_RES_LAST = 7'h58;
   localparam logic [6:0] TCI2C_SETUP_FIRST = 7'h6a;
   localparam logic [6:0] TCI2C_SETUP_LAST = 7'h6f;
   localparam logic [6:0] TCI2C_MEAS_FIRST = 7'h70;
   localparam logic [6:0] TCI2C_MEAS_LAST = 7'h7f;
   localparam logic [6:0] TCI2C_XY_CMD = 7'h70;
   localparam logic [6:0] TCI2C_PTR_RESET = 7'h00;
   localparam logic [7:0] TCI2C_EOF_BYTE = 8'hff;
   localparam logic [7:0] TCI2C_UNMAPPED_BYTE = 8'h00;
   localparam logic [3:0] TCI2C_BIT_RESET = 4'h0;
   localparam logic [1:0] TCI2C_FIFO_BYTE_LAST = 2'h3;

   typedef struct packed {
      logic sda_out;
      logic sda_oe;
   } tci2c_sda_drv_s;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } tci2c_reg_wr_s;

   typedef struct packed {
      logic valid;
      logic [6:0] code;
   } tci2c_cmd_s;
endpackage : tci2c_pkg

// File: tci2c_sync.sv
// Three-stage input synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ns
module tci2c_sync (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic async_in,
   output logic sync_out
);
   import tci2c_pkg::*;
   logic [TCI2C_SYNC_STAGES-1:0] stage_ff;
   logic level_ff;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         stage_ff <= '1;
      end else begin
         stage_ff <= {stage_ff[TCI2C_SYNC_STAGES-2:0], async_in};
      end
   end

   // Idle bus level is high, so the held level starts high.
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         level_ff <= 1'b1;
      end else if (stage_ff[1] == stage_ff[2]) begin
         level_ff <= stage_ff[2];
      end
   end

   assign sync_out = level_ff;
endmodule : tci2c_sync

// File: tci2c_ptr.sv
// Next-pointer arithmetic for read advance, with saturation and a fixed FIFO port.
`timescale 1ns/1ns
module tci2c_ptr (
   input wire logic [6:0] ptr_in,
   output logic [6:0] nxt_ptr_out
);
   import tci2c_pkg::*;

   always_comb begin
      if (ptr_in == TCI2C_FIFO_PORT) begin
         nxt_ptr_out = ptr_in;
      end else if (ptr_in == TCI2C_RES_LAST) begin
         nxt_ptr_out = ptr_in;
      end else if (ptr_in == TCI2C_CFG_LAST) begin
         nxt_ptr_out = ptr_in;
      end else begin
         nxt_ptr_out = ptr_in + 7'h01;
      end
   end
endmodule : tci2c_ptr

// File: tci2c_mstr.sv
// Behavioural I2C bus master that drives SCL and releases SDA to the pull-up.
`timescale 1ns/1ns
module tci2c_mstr (
   input wire logic mclk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   // A released line reads high through the pull-up, so a one here means released.
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic wt();
      repeat (8) @(posedge mclk_in);
      #1;
   endtask : wt
   // SDA only moves a quarter bit after SCL falls, so no edge pair looks like START or STOP.
   task automatic start();
      wt();
      sda_out = 1'b1;
      wt();
      scl_out = 1'b1;
      wt();
      sda_out = 1'b0;
      wt();
      scl_out = 1'b0;
   endtask : start
   task automatic stop();
      wt();
      sda_out = 1'b0;
      wt();
      scl_out = 1'b1;
      wt();
      sda_out = 1'b1;
      wt();
   endtask : stop
   task automatic bit_io(input logic b, output logic r);
      wt();
      sda_out = b;
      wt();
      scl_out = 1'b1;
      wt();
      r = sda_in;
      wt();
      scl_out = 1'b0;
   endtask : bit_io
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(nak, r);
   endtask : rbyte
endmodule : tci2c_mstr

// File: tci2c_target_sva.sv
// Concurrent checks on the port behaviour of the touch controller I2C target.
`timescale 1ns/1ns
module tci2c_target_sva (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic scl_in,
   input wire logic auto_mode_in,
   input wire logic conv_busy_in,
   input wire tci2c_pkg::tci2c_sda_drv_s sda_drv_out,
   input wire tci2c_pkg::tci2c_reg_wr_s reg_wr_out,
   input wire tci2c_pkg::tci2c_cmd_s cmd_out,
   input wire logic [6:0] rd_addr_out,
   input wire logic fifo_pop_out,
   input wire logic fifo_byte_adv_out,
   input wire logic [6:0] ptr_out
);
   import tci2c_pkg::*;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence s_wr_pulse;
      reg_wr_out.valid ##1 !reg_wr_out.valid;
   endsequence
   sequence s_xy_cmd;
      cmd_out.valid && cmd_out.code == TCI2C_XY_CMD;
   endsequence
   chk_wr_not_cmd: assert property (
      reg_wr_out.valid |-> !(reg_wr_out.addr inside {[TCI2C_SETUP_FIRST:TCI2C_MEAS_LAST]}))
      else $error("register write to a command code");
   chk_wr_ptr: assert property (
      s_wr_pulse |-> rd_addr_out == $past(reg_wr_out.addr)) else $error("write left pointer");
   chk_xy_ptr: assert property (
      s_xy_cmd |-> ##[0:2] rd_addr_out == TCI2C_RES_FIRST) else $error("xy pointer wrong");
   chk_cmd_range: assert property (
      cmd_out.valid |-> cmd_out.code inside {[TCI2C_SETUP_FIRST:TCI2C_MEAS_LAST]})
      else $error("command code out of range");
   chk_cmd_idle: assert property (
      cmd_out.valid |-> !$past(conv_busy_in)) else $error("command taken while busy");
   chk_fifo_hold: assert property (
      fifo_byte_adv_out |-> ptr_out == TCI2C_FIFO_PORT) else $error("fifo pointer moved");
   chk_pop_once: assert property (
      fifo_pop_out |-> (auto_mode_in && rd_addr_out == TCI2C_FIFO_PORT) ##1 !fifo_pop_out)
      else $error("bad block release");
   chk_sat_top: assert property (
      !(rd_addr_out inside {[7'h59:7'h5f]})) else $error("pointer past last result");
   chk_oe_low: assert property (
      $rose(sda_drv_out.sda_oe) |-> !scl_in) else $error("drive began with clock high");
   chk_reset_vals: assert property (disable iff (1'b0)
      !resetn_in |=> rd_addr_out == TCI2C_PTR_RESET && !sda_drv_out.sda_oe && !cmd_out.valid)
      else $error("reset values wrong");
endmodule : tci2c_target_sva
bind tci2c_target tci2c_target_sva i_sva (.mclk_in, .resetn_in, .scl_in, .auto_mode_in,
   .conv_busy_in, .sda_drv_out, .reg_wr_out, .cmd_out, .rd_addr_out, .fifo_pop_out,
   .fifo_byte_adv_out, .ptr_out);

// File: touch_ctrl_i2c_register_access_bench.sv
// Self-checking bench for the touch controller I2C target logic.
`timescale 1ns/1ns
module touch_ctrl_i2c_register_access_bench;
   import tci2c_pkg::*;
   localparam logic [6:0] dev_addr = {TCI2C_ADDR_HI, 2'h2};
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic stream_en = 1'b1;
   logic auto_mode = 1'b0;
   logic conv_busy = 1'b0;
   logic rd_pending = 1'b0;
   logic fifo_empty = 1'b0;
   logic mst_scl, mst_sda, sda, ack, ack_all;
   logic [7:0] got [8];
   logic [6:0] p, rd_addr, ptr;
   logic [14:0] wq [$];
   logic [6:0] cq [$];
   logic fifo_pop, byte_adv;
   int n_fail = 0;
   int n_compared = 0;
   int n_pop = 0;
   int n_adv = 0;
   tci2c_sda_drv_s drv;
   tci2c_reg_wr_s reg_wr;
   tci2c_cmd_s cmd;
   always #2 mclk_in = ~mclk_in;
   assign sda = mst_sda & (~drv.sda_oe | drv.sda_out);
   tci2c_mstr i_mst (.mclk_in(mclk_in), .sda_in(sda), .scl_out(mst_scl), .sda_out(mst_sda));
   tci2c_target i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .scl_in(mst_scl),
      .sda_in(sda), .sda_drv_out(drv), .addr_sel_in(2'h2), .stream_en_in(stream_en),
      .auto_mode_in(auto_mode), .conv_busy_in(conv_busy), .reg_wr_out(reg_wr),
      .cmd_out(cmd), .rd_addr_out(rd_addr), .rd_data_in({rd_addr, 1'b0}),
      .rd_pending_in(rd_pending), .fifo_empty_in(fifo_empty), .fifo_data_in(8'ha5),
      .fifo_pop_out(fifo_pop), .fifo_byte_adv_out(byte_adv), .ptr_out(ptr));
   always @(posedge mclk_in) begin
      if (reg_wr.valid === 1'b1)
         wq.push_back({reg_wr.addr, reg_wr.data});
      if (cmd.valid === 1'b1)
         cq.push_back(cmd.code);
      if (fifo_pop === 1'b1)
         n_pop++;
      if (byte_adv === 1'b1)
         n_adv++;
   end
   task automatic report_and_stop();
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input int n, input logic [31:0] b);
      ack_all = 1'b1;
      i_mst.start();
      i_mst.wbyte({dev_addr, 1'b0}, ack);
      ack_all &= ack;
      for (int i = 0; i < n; i++) begin
         i_mst.wbyte(b[31 - 8 * i -: 8], ack);
         ack_all &= ack;
      end
      i_mst.stop();
      chk(16'(ack_all), 16'h1);
   endtask : wr
   task automatic rd(input logic full, input logic [6:0] r, input int n);
      if (full) begin
         i_mst.start();
         i_mst.wbyte({dev_addr, 1'b0}, ack);
         i_mst.wbyte({1'b0, r}, ack);
      end
      i_mst.start();
      i_mst.wbyte({dev_addr, 1'b1}, ack);
      for (int i = 0; i < n; i++)
         i_mst.rbyte(i == n - 1, got[i]);
      i_mst.stop();
   endtask : rd
   task automatic t_addr();
      i_mst.start();
      i_mst.wbyte({TCI2C_ADDR_HI, 2'h1, 1'b0}, ack);
      i_mst.stop();
      chk(16'(ack), 16'h0);
      wr(0, 32'h0);
   endtask : t_addr
   task automatic t_write();
      wq.delete();
      // The first address byte carries a set top bit, which a write must ignore.
      wr(4, 32'h8133_0b44);
      chk(16'(wq.size()), 16'h2);
      chk(16'(wq[0]), 16'({7'h01, 8'h33}));
      chk(16'(wq[1]), 16'({TCI2C_OPMODE_REG, 8'h44}));
      chk(16'(ptr), 16'(TCI2C_OPMODE_REG));
      rd(1'b0, 7'h00, 1);
      chk(16'(got[0]), 16'({TCI2C_OPMODE_REG, 1'b0}));
   endtask : t_write
   task automatic t_read();
      rd(1'b1, TCI2C_RES_FIRST, 3);
      for (int i = 0; i < 3; i++)
         chk(16'(got[i]), 16'({7'h52 + 7'(i), 1'b0}));
      chk(16'(ptr), 16'h55);
      rd(1'b0, 7'h00, 1);
      chk(16'(got[0]), 16'({7'h55, 1'b0}));
      rd(1'b1, 7'h57, 4);
      chk(16'(got[0]), 16'({7'h57, 1'b0}));
      for (int i = 1; i < 4; i++)
         chk(16'(got[i]), 16'({TCI2C_RES_LAST, 1'b0}));
   endtask : t_read
   task automatic t_stream();
      stream_en = 1'b0;
      rd(1'b0, 7'h00, 1);
      stream_en = 1'b1;
      chk(16'(got[0]), 16'(TCI2C_UNMAPPED_BYTE));
   endtask : t_stream
   task automatic t_cmd();
      p = ptr;
      cq.delete();
      conv_busy = 1'b1;
      wr(1, {1'b0, TCI2C_XY_CMD, 24'h0});
      conv_busy = 1'b0;
      chk(16'(cq.size()), 16'h0);
      chk(16'(ptr), 16'(p));
      wr(2, {1'b0, TCI2C_XY_CMD, 24'h0});
      chk(16'(cq.size()), 16'h0);
      wr(1, {1'b0, TCI2C_XY_CMD, 24'h0});
      chk(16'(cq.size()), 16'h1);
      chk(16'(cq[0]), 16'(TCI2C_XY_CMD));
      chk(16'(ptr), 16'(TCI2C_RES_FIRST));
   endtask : t_cmd
   task automatic t_pend();
      rd_pending = 1'b1;
      rd(1'b1, TCI2C_RES_FIRST, 1);
      rd_pending = 1'b0;
      chk(16'(got[0]), 16'({TCI2C_RES_FIRST, 1'b1}));
   endtask : t_pend
   task automatic t_fifo();
      auto_mode = 1'b1;
      n_pop = 0;
      n_adv = 0;
      rd(1'b1, TCI2C_FIFO_PORT, 8);
      chk(16'(got[0]), 16'ha5);
      chk(16'(ptr), 16'(TCI2C_FIFO_PORT));
      chk(16'(n_pop), 16'h2);
      chk(16'(n_adv), 16'h8);
      rd(1'b0, 7'h00, 1);
      chk(16'(n_pop), 16'h3);
      fifo_empty = 1'b1;
      rd(1'b0, 7'h00, 1);
      fifo_empty = 1'b0;
      auto_mode = 1'b0;
      chk(16'(got[0]), 16'(TCI2C_EOF_BYTE));
   endtask : t_fifo
   initial begin
      repeat (10) @(posedge mclk_in);
      #1;
      resetn_in = 1'b1;
      repeat (8) @(posedge mclk_in);
      t_addr();
      t_write();
      t_read();
      t_stream();
      t_cmd();
      t_pend();
      t_fifo();
      report_and_stop();
   end
   // About fifty bytes of bus traffic take some 60 us; the limit leaves a wide margin.
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule : touch_ctrl_i2c_register_access_bench
